// [dv/fabric_model.sv]
// Neighbouring fabric that supplies the routed tile clock.
`timescale 1ns/1ps
module fabric_model (
   input wire logic sys_clk,
   input wire logic run,
   output logic tile_clk
);
   logic [1:0] div_q;
   logic [1:0] div_d;
   // The clock stands low whenever the fabric is idle.
   always_comb begin
      div_d = run ? div_q + 2'h1 : 2'h0;
   end
   always_ff @(posedge sys_clk) begin
      div_q <= div_d;
   end
   assign tile_clk = div_q[1];
endmodule

// [dv/logic_tile_tb.sv]
// Self-checking bench of the programmable logic tile.
`timescale 1ns/1ps
module logic_tile_tb;
   import tile_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wait_r;
   logic [31:0] v;
   tile_in_t ri = '0;
   tile_in_t rin;
   tile_out_t ro;
   logic cin = 1'b0;
   logic run = 1'b0;
   logic fab_clk;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   always_comb begin
      rin = ri;
      rin.clk = fab_clk;
   end
   fabric_model fabric_model_i (.sys_clk(sys_clk), .run(run), .tile_clk(fab_clk));
   logic_tile logic_tile_i (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
      .avs_readdata(rdat), .avs_waitrequest(wait_r), .route_in(rin), .carry_in(cin),
      .wide_in(1'b0), .route_out(ro), .wide_out());
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wdat <= d;
      // Waitrequest is sampled at the edge itself, so the request stands until it is seen low.
      do begin
         @(posedge sys_clk);
      end while (wait_r !== 1'b0);
      v = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(v, e);
   endtask
   task automatic qchk(input int n, input logic e);
      repeat (n) @(posedge sys_clk);
      #1;
      check({31'h0, ro.slice[0].q[0]}, {31'h0, e});
   endtask
   task automatic t_reset();
      rchk(CTRL_OFS, 32'h0);
      rchk(STATUS_OFS, 32'h0);
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      rchk(8'h40, 32'h0);
      rchk(8'h08, 32'h0);
   endtask
   task automatic t_lut();
      logic [15:0] p [8];
      logic [7:0] e;
      for (int k = 0; k < 8; k++) begin
         p[k] = 16'h8421 ^ (16'h0101 << k);
         bus(1'b1, 8'h20 + 8'(4 * k), {16'h0, p[k]});
      end
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         for (int s = 0; s < 4; s++) ri.slice[s] <= '{4'(i), 4'(i), 2'h1, 2'h0};
         #1;
         for (int k = 0; k < 8; k++) e[k] = p[k][i];
         check({24'h0, ro.slice[3].f, ro.slice[2].f, ro.slice[1].f, ro.slice[0].f}, {24'h0, e});
      end
   endtask
   task automatic t_carry();
      for (int k = 0; k < 8; k++) bus(1'b1, 8'h20 + 8'(4 * k), 32'hFFFF);
      for (int s = 0; s < 4; s++) bus(1'b1, 8'h10 + 8'(4 * s), 32'h1);
      for (int c = 0; c < 2; c++) begin
         @(posedge sys_clk);
         cin <= c[0];
         #1;
         check({27'h0, ro.fco, ro.slice[3].f, ro.slice[0].f}, {27'h0, c[0], {4{~c[0]}}});
      end
   endtask
   task automatic t_reg();
      bus(1'b1, 8'h10, 32'h300);
      rchk(STATUS_OFS, 32'h1);
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, CTRL_OFS, 32'h3);
      ri.ce <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bus(1'b0, STATUS_OFS, 32'h0);
      check(v & 32'h101, 32'h100);
      @(posedge sys_clk);
      ri.lsr <= 1'b1;
      qchk(1, 1'b1);
      ri.lsr <= 1'b0;
      qchk(2, 1'b0);
      ri.ce <= 1'b0;
      bus(1'b1, 8'h20, 32'hFFFF);
      qchk(3, 1'b0);
      ri.ce <= 1'b1;
      qchk(2, 1'b1);
   endtask
   task automatic t_ram();
      bus(1'b1, 8'h10, 32'h3);
      bus(1'b1, 8'h1C, 32'h3);
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, 8'h38, 32'h0);
      @(posedge sys_clk);
      ri.slice[0] <= '{4'h0, 4'h5, 2'h0, 2'h1};
      ri.slice[3] <= '{4'h0, 4'h5, 2'h0, 2'h1};
      ri.wre <= 1'b1;
      ri.cs <= 1'b1;
      repeat (2) @(posedge sys_clk);
      ri.wre <= 1'b0;
      rchk(8'h20, 32'h20);
      rchk(8'h38, 32'h0);
   endtask
   task automatic t_clk();
      bus(1'b1, 8'h10, 32'h0);
      bus(1'b1, 8'h20, 32'h0);
      bus(1'b1, CTRL_OFS, 32'h1);
      bus(1'b1, 8'h20, 32'hFFFF);
      qchk(4, 1'b0);
      run <= 1'b1;
      qchk(8, 1'b1);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_lut();
      t_carry();
      t_reg();
      t_ram();
      t_clk();
      finish_test();
   end
endmodule
bind logic_tile tile_props tile_props_i (.sys_clk(sys_clk), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .route_in(route_in),
   .carry_in(carry_in), .route_out(route_out));

// [dv/tile_props.sv]
// Port level checks of the logic tile.
`timescale 1ns/1ps
module tile_props
import tile_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire tile_pkg::tile_in_t route_in,
   input wire logic carry_in,
   input wire tile_pkg::tile_out_t route_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic req;
   assign req = avs_read | avs_write;
   chk_wait_one: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus wait not one cycle");
   chk_idle_ready: assert property (!req |-> !avs_waitrequest)
      else $error("wait raised while idle");
   chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without read");
   chk_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
      (avs_address[7:6] != 2'h0 || avs_address[5:3] == 3'h1) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_q_cleared: assert property ($rose(rst_b) |-> route_out.slice[0].q == 2'h0)
      else $error("register not at init after reset");
   chk_comb_stable: assert property ($stable(route_in) && $stable(carry_in) &&
      !route_in.wre && !$past(avs_write) |-> $stable(route_out.fco) && $stable(route_out.slice[0].f))
      else $error("lookup output moved with steady inputs");
   chk_ofx_mux: assert property (route_out.slice[0].ofx[0] ==
      (route_in.slice[0].m[0] ? route_out.slice[0].f[1] : route_out.slice[0].f[0]))
      else $error("combining mux wrong");
   chk_six_mux: assert property (route_out.slice[1].ofx[1] ==
      (route_in.slice[1].m[1] ? route_out.slice[1].ofx[0] : route_out.slice[0].ofx[0]))
      else $error("six input mux wrong");
   chk_ce_hold: assert property (!route_in.ce && !route_in.lsr && !avs_write &&
      !$past(avs_write) ##1 !route_in.lsr |-> $stable(route_out.slice[0].q))
      else $error("register moved with enable low");
   cover property (avs_write && !avs_waitrequest);
   cover property (avs_read && !avs_waitrequest);
   cover property ($rose(route_out.fco));
endmodule

// [rtl/logic_tile.sv]
// Programmable logic tile with four slices, configured over Avalon-MM.
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
module logic_tile (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire tile_pkg::tile_in_t route_in,
   input wire logic carry_in,
   input wire logic wide_in,
   output tile_pkg::tile_out_t route_out,
   output logic wide_out
);
   import tile_pkg::*;

   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [NUM_SLICES-1:0][31:0] cfg_q;
   logic [NUM_SLICES-1:0][31:0] cfg_d;
   logic [NUM_LUTS-1:0][15:0] lut_q;
   logic [NUM_LUTS-1:0][15:0] lut_d;
   logic [NUM_LUTS-1:0] q_q;
   logic [NUM_LUTS-1:0] q_d;
   logic clk_q;
   logic ack_q;
   logic ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   logic req;
   logic wr_take;
   logic cfg_hit;
   logic lut_hit;
   logic user;
   logic free;
   logic rise;
   logic fall;
   logic [NUM_SLICES:0] carry;
   logic [NUM_SLICES-1:0][1:0] f;
   logic [NUM_SLICES-1:0][1:0] d_in;
   logic [NUM_SLICES-1:0] l5;
   logic [1:0] l6;
   logic l7;
   logic l8;
   logic [NUM_SLICES-1:0] ofx1;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] w,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b+:8] = w[8*b+:8];
         end
      end
      return m;
   endfunction

   // A RAM request on a slice without write ports falls back to ROM.
   function automatic slice_mode_t eff_mode(input logic [31:0] cfg, input int s);
      slice_mode_t mode;
      mode = slice_mode_t'(cfg[1:0]);
      if (s >= RAM_SLICES && mode == MODE_RAM) begin
         mode = MODE_ROM;
      end
      return mode;
   endfunction

   function automatic logic reg_bit(input logic [31:0] cfg, input int r, input int field);
      return cfg[CFG_REG_LSB + r * CFG_REG_STRIDE + field];
   endfunction

   // Register bus: every access sees one wait cycle, then completes.
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata = rdata_q;
   assign wr_take = avs_write & ack_q;
   assign cfg_hit = (avs_address[7:4] == CFG_PAGE);
   assign lut_hit = (avs_address[7:5] == LUT_PAGE);

   always_comb begin
      ack_d = req & ~ack_q;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      cfg_d = cfg_q;
      if (avs_read && !ack_q) begin
         rdata_d = 32'h0000_0000;
         if (avs_address[7:2] == CTRL_OFS[7:2]) begin
            rdata_d = ctrl_q;
         end else if (avs_address[7:2] == STATUS_OFS[7:2]) begin
            rdata_d = {23'h000000, user, q_q};
         end else if (cfg_hit) begin
            rdata_d = cfg_q[avs_address[3:2]];
         end else if (lut_hit) begin
            rdata_d = {16'h0000, lut_q[avs_address[4:2]]};
         end
      end
      if (wr_take) begin
         if (avs_address[7:2] == CTRL_OFS[7:2]) begin
            ctrl_d = merge(ctrl_q, avs_writedata, avs_byteenable) & CTRL_MASK;
         end else if (cfg_hit) begin
            cfg_d[avs_address[3:2]] = merge(cfg_q[avs_address[3:2]], avs_writedata,
                                            avs_byteenable) & CFG_MASK;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ctrl_q <= CTRL_RST;
         cfg_q <= {NUM_SLICES{CFG_RST}};
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         cfg_q <= cfg_d;
      end
   end

   // Tile clock: routed clock edges, or every cycle when free running is selected.
   assign user = ctrl_q[CTRL_USER_BIT];
   assign free = ctrl_q[CTRL_FREE_BIT];
   assign rise = free | (route_in.clk & ~clk_q);
   assign fall = free | (~route_in.clk & clk_q);

   assign carry[0] = carry_in;

   genvar s;
   generate
      for (s = 0; s < NUM_SLICES; s++) begin : g_slice
         slice_route_t rin;
         slice_mode_t mode;
         logic [1:0] lo;
         logic sum0;
         logic sum1;
         logic c1;
         logic cout;
         assign rin = route_in.slice[s];
         assign mode = eff_mode(cfg_q[s], s);
         assign lo[0] = lut_q[2*s][rin.lut0];
         assign lo[1] = lut_q[2*s+1][rin.lut1];
         // Lookup gives propagate, input A of each lookup gives generate.
         assign sum0 = lo[0] ^ carry[s];
         assign c1 = lo[0] ? carry[s] : rin.lut0[0];
         assign sum1 = lo[1] ^ c1;
         assign cout = lo[1] ? c1 : rin.lut1[0];
         assign f[s] = (mode == MODE_RIPPLE) ? {sum1, sum0} : lo;
         assign carry[s+1] = (mode == MODE_RIPPLE) ? cout : carry[s];
         assign l5[s] = rin.m[0] ? f[s][1] : f[s][0];
         assign d_in[s][0] = reg_bit(cfg_q[s], 0, REG_DSEL) ? rin.m[0] : f[s][0];
         assign d_in[s][1] = reg_bit(cfg_q[s], 1, REG_DSEL) ? rin.m[1] : f[s][1];
         assign route_out.slice[s].f = f[s];
         assign route_out.slice[s].q = q_q[2*s+1:2*s];
         assign route_out.slice[s].ofx = {ofx1[s], l5[s]};
      end
   endgenerate

   // Wider functions: pairs make six inputs, the tile seven, two tiles eight.
   assign l6[0] = route_in.slice[1].m[1] ? l5[1] : l5[0];
   assign l6[1] = route_in.slice[3].m[1] ? l5[3] : l5[2];
   assign l7 = route_in.slice[0].m[1] ? l6[1] : l6[0];
   assign l8 = route_in.slice[2].m[1] ? wide_in : l7;
   assign ofx1 = {l6[1], l8, l6[0], l7};
   assign wide_out = l7;
   assign route_out.fco = carry[NUM_SLICES];

   // Slice registers.
   always_comb begin
      logic [31:0] c;
      logic init;
      logic hit;
      int r;
      c = 32'h0000_0000;
      init = 1'b0;
      hit = 1'b0;
      r = 0;
      q_d = q_q;
      for (int k = 0; k < NUM_LUTS; k++) begin
         c = cfg_q[k/LUTS_PER_SLICE];
         r = k % LUTS_PER_SLICE;
         init = reg_bit(c, r, REG_INIT);
         if (reg_bit(c, r, REG_LEVEL)) begin
            hit = free | (reg_bit(c, r, REG_NEG) ? ~route_in.clk : route_in.clk);
         end else begin
            hit = reg_bit(c, r, REG_NEG) ? fall : rise;
         end
         if (!user) begin
            q_d[k] = init;
         end else if (route_in.lsr && reg_bit(c, r, REG_ASYNC)) begin
            q_d[k] = init;
         end else if (hit) begin
            if (route_in.lsr) begin
               q_d[k] = init;
            end else if (route_in.ce) begin
               q_d[k] = d_in[k/LUTS_PER_SLICE][r];
            end
         end
      end
   end

   // Lookup contents: bus writes, then distributed RAM writes on top.
   always_comb begin
      logic [31:0] w;
      slice_route_t sr;
      w = 32'h0000_0000;
      sr = '0;
      lut_d = lut_q;
      if (wr_take && lut_hit) begin
         w = merge({16'h0000, lut_q[avs_address[4:2]]}, avs_writedata, avs_byteenable);
         lut_d[avs_address[4:2]] = w[15:0];
      end
      for (int k = 0; k < RAM_SLICES * LUTS_PER_SLICE; k++) begin
         sr = route_in.slice[k/LUTS_PER_SLICE];
         if (user && rise && route_in.wre && route_in.cs &&
             eff_mode(cfg_q[k/LUTS_PER_SLICE], k/LUTS_PER_SLICE) == MODE_RAM) begin
            if (k % LUTS_PER_SLICE == 0) begin
               lut_d[k][sr.lut0] = sr.wd[0];
            end else begin
               lut_d[k][sr.lut1] = sr.wd[1];
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_q <= 1'b0;
         q_q <= Q_RST;
         lut_q <= {NUM_LUTS{LUT_RST}};
      end else begin
         clk_q <= route_in.clk;
         q_q <= q_d;
         lut_q <= lut_d;
      end
   end
endmodule

// [rtl/tile_pkg.sv]
// Shared constants, types and register map of the programmable logic tile.
package tile_pkg;
   localparam int NUM_SLICES = 4;
   localparam int LUTS_PER_SLICE = 2;
   localparam int NUM_LUTS = 8;
   localparam int LUT_DEPTH = 16;
   localparam int RAM_SLICES = 3;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [3:0] CFG_PAGE = 4'h1;
   localparam logic [2:0] LUT_PAGE = 3'h1;
   localparam int CTRL_USER_BIT = 0;
   localparam int CTRL_FREE_BIT = 1;
   localparam int CFG_REG_LSB = 8;
   localparam int CFG_REG_STRIDE = 8;
   localparam int REG_INIT = 0;
   localparam int REG_ASYNC = 1;
   localparam int REG_NEG = 2;
   localparam int REG_LEVEL = 3;
   localparam int REG_DSEL = 4;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
   localparam logic [31:0] CFG_MASK = 32'h001F_1F03;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [15:0] LUT_RST = 16'h0000;
   localparam logic [7:0] Q_RST = 8'h00;

   typedef enum logic [1:0] {
      MODE_LOGIC = 2'b00,
      MODE_RIPPLE = 2'b01,
      MODE_RAM = 2'b11,
      MODE_ROM = 2'b10
   } slice_mode_t;

   typedef struct packed {
      logic [3:0] lut1;
      logic [3:0] lut0;
      logic [1:0] m;
      logic [1:0] wd;
   } slice_route_t;

   typedef struct packed {
      slice_route_t [3:0] slice;
      logic clk;
      logic lsr;
      logic ce;
      logic wre;
      logic cs;
   } tile_in_t;

   typedef struct packed {
      logic [1:0] f;
      logic [1:0] q;
      logic [1:0] ofx;
   } slice_out_t;

   typedef struct packed {
      slice_out_t [3:0] slice;
      logic fco;
   } tile_out_t;
endpackage
